//--- hw/combiner_aggregator_status.sv
// Combiner and aggregator status register bank with interrupt.
//
// Notes on behaviour
// - Bits 21..16 of the combiner status show per-link output queue overflow.
// - Bits 13..8 of the combiner status show per-link output queue underflow.
// - Bits 1..0 of the combiner status show alignment error per combiner.
// - Writing one to a live aggregator bit inverts that bit.
// - A hardware detection in the clearing cycle keeps the bit set.
// - Each link has sixteen carrier summation overflow flags, upper bits zero.
// - Header errors cover 84 slots, 21 per register, four registers a link.
// - The first header register bit n reports slot n.
// - The second header register bit n reports slot 21 plus n.
// - The third header register bit n reports slot 42 plus n.
// - The fourth header register bit n reports slot 63 plus n.
// - Every link has its own identical set of these five registers.
// - All status bits read zero after reset.
// - Writes to the combiner status register change nothing.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module combiner_aggregator_status
   import agg_status_pkg::*;
(
   input  wire logic               mclk,
   input  wire logic               rst,
   input  wire logic [ADDR_W-1:0]  reg_addr,
   input  wire logic [DATA_W-1:0]  reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic      [DATA_W-1:0]  reg_rdata,
   input  wire combiner_flags_type combiner_flags,
   input  wire link_events_type    link_events [NUM_LINKS],
   output logic                    irq
);
   initial begin
      if (NUM_LINKS != 6 || SLOTS_TOTAL != HDR_REGS * SLOTS_PER_REG)
         $error("Unsupported link or slot count.");
   end

   reg_req_type req;
   assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

   logic [DATA_W-1:0] combiner_q;
   logic [CARRIER_FLAGS-1:0] sum_q [NUM_LINKS];
   logic [SLOTS_TOTAL-1:0]   hdr_q [NUM_LINKS];
   logic [IRQ_W-1:0]         irq_status_q;
   logic [IRQ_W-1:0]         irq_enable_q;

   // Link index of a per-link address, or NUM_LINKS when outside the blocks.
   function automatic logic [2:0] link_of(input logic [11:0] a);
      logic [11:0] rel;
      rel = a - LINK_BASE_OFFSET;
      if (a < LINK_BASE_OFFSET || rel >= 12'(NUM_LINKS) * LINK_STRIDE)
         return 3'(NUM_LINKS);
      return rel[7:5];
   endfunction

   // Byte offset of the addressed word within a link block.
   function automatic logic [4:0] word_of(input logic [11:0] a);
      return {2'b00, a[4:2]} << 2;
   endfunction

   // Combiner status mirrors live flags; it has no write path.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         combiner_q <= STATUS_RESET;
      end else begin
         combiner_q <= STATUS_RESET;
         combiner_q[OVF_LSB +: NUM_LINKS] <= combiner_flags.ovf;
         combiner_q[UNF_LSB +: NUM_LINKS] <= combiner_flags.unf;
         combiner_q[ALIGN_LSB +: NUM_COMBINERS] <= combiner_flags.align;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_LINKS; g++) begin : g_link
         logic hit;
         logic [4:0] wsel;
         assign hit  = req.wr && link_of(req.addr) == 3'(g);
         assign wsel = word_of(req.addr);

         always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
               sum_q[g] <= '0;
            end else begin
               // Invert, then OR in new detections so the set wins.
               sum_q[g] <= (sum_q[g] ^ ((hit && wsel == SUM_OVF_WORD) ?
                           req.wdata[CARRIER_FLAGS-1:0] : '0))
                           | link_events[g].sum_ovf;
            end
         end

         for (genvar r = 0; r < HDR_REGS; r++) begin : g_hdr
            always_ff @(posedge mclk or posedge rst) begin
               if (rst) begin
                  hdr_q[g][r*SLOTS_PER_REG +: SLOTS_PER_REG] <= '0;
               end else begin
                  // Register r bit n is slot 21*r+n.
                  hdr_q[g][r*SLOTS_PER_REG +: SLOTS_PER_REG] <=
                     (hdr_q[g][r*SLOTS_PER_REG +: SLOTS_PER_REG] ^
                      ((hit && wsel == HDR_WORD0 + 5'(4 * r)) ?
                       req.wdata[SLOTS_PER_REG-1:0] : '0))
                     | link_events[g].header_error_slot_flags[r*SLOTS_PER_REG +: SLOTS_PER_REG];
               end
            end
         end
      end
   endgenerate

   // Interrupt events: any new detection sets a sticky bit.
   logic [IRQ_W-1:0] irq_event;
   always_comb begin
      irq_event = '0;
      irq_event[0] = |combiner_flags;
      for (int i = 0; i < NUM_LINKS; i++)
         irq_event[i+1] = |link_events[i];
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_status_q <= '0;
      end else begin
         irq_status_q <= (irq_status_q & ~((req.wr &&
                          req.addr == IRQ_CLEAR_OFFSET) ?
                          req.wdata[IRQ_W-1:0] : '0)) | irq_event;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_enable_q <= '0;
      end else if (req.wr && req.addr == IRQ_ENABLE_OFFSET) begin
         irq_enable_q <= req.wdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((irq_status_q & ~((req.wr && req.addr == IRQ_CLEAR_OFFSET)
                ? req.wdata[IRQ_W-1:0] : '0)) | irq_event) &
                ((req.wr && req.addr == IRQ_ENABLE_OFFSET) ?
                 req.wdata[IRQ_W-1:0] : irq_enable_q));
      end
   end

   // Read data stand one cycle after the read strobe only.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (!req.rd) begin
         reg_rdata <= '0;
      end else if (req.addr == COMBINER_OFFSET) begin
         reg_rdata <= combiner_q;
      end else if (req.addr == IRQ_STATUS_OFFSET) begin
         reg_rdata <= 32'(irq_status_q);
      end else if (req.addr == IRQ_ENABLE_OFFSET) begin
         reg_rdata <= 32'(irq_enable_q);
      end else if (link_of(req.addr) < 3'(NUM_LINKS) &&
                   req.addr[1:0] == 2'b00) begin
         if (word_of(req.addr) == SUM_OVF_WORD)
            reg_rdata <= 32'(sum_q[link_of(req.addr)]);
         else if (word_of(req.addr) >= HDR_WORD0)
            reg_rdata <= 32'(hdr_q[link_of(req.addr)][
               (word_of(req.addr) - HDR_WORD0) / 4 * SLOTS_PER_REG
               +: SLOTS_PER_REG]);
         else
            reg_rdata <= UNMAPPED_READ;
      end else begin
         reg_rdata <= UNMAPPED_READ;
      end
   end

   // Helper for the toggle check.
   logic [4:0] wsel_a;
   logic [2:0] lnk_a;
   assign wsel_a = word_of(req.addr);
   assign lnk_a  = link_of(req.addr);

   property p_combiner_ro;
      @(posedge mclk) disable iff (rst)
         (req.wr && req.addr == COMBINER_OFFSET && !$changed(combiner_flags))
         |=> combiner_q == $past(combiner_q);
   endproperty
   a_combiner_ro: assert property (p_combiner_ro)
      else $error("Combiner status changed by a write.");

   property p_ovf_field;
      @(posedge mclk) disable iff (rst)
         1'b1 |=> combiner_q[21:16] == $past(combiner_flags.ovf);
   endproperty
   a_ovf_field: assert property (p_ovf_field)
      else $error("Overflow field wrong.");

   property p_unf_field;
      @(posedge mclk) disable iff (rst)
         1'b1 |=> combiner_q[13:8] == $past(combiner_flags.unf);
   endproperty
   a_unf_field: assert property (p_unf_field)
      else $error("Underflow field wrong.");

   property p_align_reserved;
      @(posedge mclk) disable iff (rst)
         1'b1 |=> combiner_q[1:0] == $past(combiner_flags.align)
                  && combiner_q[7:2] == 6'h00 && combiner_q[31:22] == 10'h000;
   endproperty
   a_align_reserved: assert property (p_align_reserved)
      else $error("Alignment field or reserved bits wrong.");

   sequence s_toggle0;
      req.wr && lnk_a == 3'd0 && wsel_a == SUM_OVF_WORD
      && link_events[0].sum_ovf == '0;
   endsequence
   property p_toggle;
      @(posedge mclk) disable iff (rst)
         s_toggle0 |=> sum_q[0] == ($past(sum_q[0]) ^ $past(req.wdata[15:0]));
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("Write one did not invert.");

   property p_set_wins;
      @(posedge mclk) disable iff (rst)
         link_events[0].header_error_slot_flags[0] |=> hdr_q[0][0];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("Detection lost against clear.");

   property p_sticky;
      @(posedge mclk) disable iff (rst)
         (hdr_q[0][63] && !(req.wr && lnk_a == 3'd0 && wsel_a == 5'h1c
          && req.wdata[0])) |=> hdr_q[0][63];
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("Flag dropped without software.");

   property p_rdata_slot;
      @(posedge mclk) disable iff (rst)
         (req.rd && req.addr == 12'h114) |=>
         reg_rdata == 32'($past(hdr_q[0][41:21]));
   endproperty
   a_rdata_slot: assert property (p_rdata_slot)
      else $error("Second header register mapping wrong.");

   property p_rdata_slot0;
      @(posedge mclk) disable iff (rst)
         (req.rd && req.addr == 12'h110) |=>
         reg_rdata == 32'($past(hdr_q[0][20:0]));
   endproperty
   a_rdata_slot0: assert property (p_rdata_slot0)
      else $error("First header register mapping wrong.");

   property p_rdata_slot42;
      @(posedge mclk) disable iff (rst)
         (req.rd && req.addr == 12'h118) |=>
         reg_rdata == 32'($past(hdr_q[0][62:42]));
   endproperty
   a_rdata_slot42: assert property (p_rdata_slot42)
      else $error("Third header register mapping wrong.");

   property p_rdata_slot63;
      @(posedge mclk) disable iff (rst)
         (req.rd && req.addr == 12'h11c) |=>
         reg_rdata == 32'($past(hdr_q[0][83:63]));
   endproperty
   a_rdata_slot63: assert property (p_rdata_slot63)
      else $error("Fourth header register mapping wrong.");

   property p_rdata_link5;
      @(posedge mclk) disable iff (rst)
         (req.rd && req.addr == 12'h1a0) |=>
         reg_rdata == 32'($past(sum_q[5]));
   endproperty
   a_rdata_link5: assert property (p_rdata_link5)
      else $error("Last link summation register wrong.");

   property p_sum_reserved;
      @(posedge mclk) disable iff (rst)
         (req.rd && lnk_a < 3'(NUM_LINKS) && wsel_a == SUM_OVF_WORD
          && req.addr[1:0] == 2'b00) |=> reg_rdata[31:16] == 16'h0000;
   endproperty
   a_sum_reserved: assert property (p_sum_reserved)
      else $error("Summation register reserved bits not zero.");

   property p_hdr_reserved;
      @(posedge mclk) disable iff (rst)
         (req.rd && lnk_a < 3'(NUM_LINKS) && wsel_a >= HDR_WORD0
          && req.addr[1:0] == 2'b00) |=> reg_rdata[31:21] == 11'h000;
   endproperty
   a_hdr_reserved: assert property (p_hdr_reserved)
      else $error("Header register reserved bits not zero.");

   property p_reset_zero;
      @(posedge mclk)
         rst |-> reg_rdata == '0 && irq == 1'b0 && combiner_q == '0;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("Outputs not zero in reset.");

   sequence s_hdr_wr5;
      req.wr && lnk_a == 3'd5 && wsel_a == 5'h1c
      && link_events[5].header_error_slot_flags[83:63] == '0;
   endsequence
   property p_hdr_toggle;
      @(posedge mclk) disable iff (rst)
         s_hdr_wr5 |=> hdr_q[5][83:63] ==
                       ($past(hdr_q[5][83:63]) ^ $past(req.wdata[20:0]));
   endproperty
   a_hdr_toggle: assert property (p_hdr_toggle)
      else $error("Header write one did not invert.");

   property p_set_wins_sum;
      @(posedge mclk) disable iff (rst)
         link_events[3].sum_ovf[15] |=> sum_q[3][15];
   endproperty
   a_set_wins_sum: assert property (p_set_wins_sum)
      else $error("Summation detection lost against clear.");

   property p_sticky_sum;
      @(posedge mclk) disable iff (rst)
         (sum_q[2][0] && !(req.wr && lnk_a == 3'd2
          && wsel_a == SUM_OVF_WORD && req.wdata[0])) |=> sum_q[2][0];
   endproperty
   a_sticky_sum: assert property (p_sticky_sum)
      else $error("Summation flag dropped without software.");

   property p_irq_level;
      @(posedge mclk) disable iff (rst)
         1'b1 |-> irq == |(irq_status_q & irq_enable_q);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("Interrupt level does not follow status and enable.");

   property p_combiner_event;
      @(posedge mclk) disable iff (rst)
         (|combiner_flags) |=> irq_status_q[0];
   endproperty
   a_combiner_event: assert property (p_combiner_event)
      else $error("Combiner event did not set status.");
endmodule
`default_nettype wire

//--- include/agg_status_pkg.sv
// Package with register map, field layout and types of the status bank.
package agg_status_pkg;
   localparam int unsigned NUM_LINKS      = 6;
   localparam int unsigned ADDR_W         = 12;
   localparam int unsigned DATA_W         = 32;
   localparam int unsigned CARRIER_FLAGS  = 16;
   localparam int unsigned SLOTS_PER_REG  = 21;
   localparam int unsigned HDR_REGS       = 4;
   localparam int unsigned SLOTS_TOTAL    = 84;
   // Byte offsets; each link takes a block of LINK_STRIDE bytes.
   localparam logic [11:0] COMBINER_OFFSET      = 12'h000;
   localparam logic [11:0] IRQ_STATUS_OFFSET    = 12'h004;
   localparam logic [11:0] IRQ_CLEAR_OFFSET     = 12'h008;
   localparam logic [11:0] IRQ_ENABLE_OFFSET    = 12'h00c;
   localparam logic [11:0] LINK_BASE_OFFSET     = 12'h100;
   localparam logic [11:0] LINK_STRIDE          = 12'h020;
   localparam logic [4:0]  SUM_OVF_WORD         = 5'h00;
   localparam logic [4:0]  HDR_WORD0            = 5'h10;
   // Combiner status field positions.
   localparam int unsigned OVF_LSB   = 16;
   localparam int unsigned UNF_LSB   = 8;
   localparam int unsigned ALIGN_LSB = 0;
   localparam int unsigned NUM_COMBINERS = 2;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   // Interrupt event bits: 0 combiner, 1..6 aggregator per link.
   localparam int unsigned IRQ_W = 7;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

   typedef struct packed {
      logic [NUM_LINKS-1:0]     ovf;
      logic [NUM_LINKS-1:0]     unf;
      logic [NUM_COMBINERS-1:0] align;
   } combiner_flags_type;

   typedef struct packed {
      logic [CARRIER_FLAGS-1:0] sum_ovf;
      logic [SLOTS_TOTAL-1:0]   header_error_slot_flags;
   } link_events_type;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [11:0]       addr;
      logic [31:0]       wdata;
   } reg_req_type;
endpackage

//--- verification/test_combiner_aggregator_status.sv
// Self-checking testbench for the combiner and aggregator status bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin errors++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module test_combiner_aggregator_status
   import agg_status_pkg::*;
;
   logic               mclk = 1'b0;
   logic               rst = 1'b1;
   logic [ADDR_W-1:0]  reg_addr = '0;
   logic [DATA_W-1:0]  reg_wdata = '0;
   logic               reg_wr = 1'b0;
   logic               reg_rd = 1'b0;
   logic [DATA_W-1:0]  reg_rdata;
   combiner_flags_type combiner_flags = '0;
   link_events_type    link_events [NUM_LINKS];
   logic               irq;
   int                 errors = 0;
   int                 n_tests = 0;

   always #5 mclk = ~mclk;

   combiner_aggregator_status combiner_aggregator_status_inst (
      .mclk           (mclk),
      .rst            (rst),
      .reg_addr       (reg_addr),
      .reg_wdata      (reg_wdata),
      .reg_wr         (reg_wr),
      .reg_rd         (reg_rd),
      .reg_rdata      (reg_rdata),
      .combiner_flags (combiner_flags),
      .link_events    (link_events),
      .irq            (irq)
   );

   function automatic logic [11:0] link_addr(input int k, input int w);
      return LINK_BASE_OFFSET + LINK_STRIDE * 12'(k) + 12'(4 * w);
   endfunction

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic chk_rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 `CHK(reg_rdata, exp)
   endtask

   task automatic pulse(input int k, input logic [15:0] s,
                        input logic [83:0] h);
      @(posedge mclk);
      link_events[k].sum_ovf <= s;
      link_events[k].header_error_slot_flags <= h;
      @(posedge mclk);
      link_events[k] <= '0;
   endtask

   task automatic t_reset();
      chk_rd(COMBINER_OFFSET, 32'h0);
      for (int k = 0; k < 6; k++) begin
         for (int w = 0; w < 8; w = (w == 0) ? 4 : w + 1) begin
            chk_rd(link_addr(k, w), 32'h0);
         end
      end
      `CHK(irq, 1'b0)
   endtask

   task automatic t_combiner();
      combiner_flags_type p [2];
      logic [31:0] e;
      p[0] = '{ovf: 6'h21, unf: 6'h12, align: 2'h2};
      p[1] = '{ovf: 6'h3f, unf: 6'h3f, align: 2'h3};
      for (int i = 0; i < 2; i++) begin
         e = (32'(p[i].ovf) << 16) | (32'(p[i].unf) << 8) | 32'(p[i].align);
         combiner_flags <= p[i];
         repeat (2) @(posedge mclk);
         chk_rd(COMBINER_OFFSET, e);
         wr(COMBINER_OFFSET, 32'hffff_ffff);
         chk_rd(COMBINER_OFFSET, e);
      end
      combiner_flags <= '0;
      repeat (3) @(posedge mclk);
   endtask

   task automatic t_links();
      logic [83:0] h;
      logic [15:0] s;
      for (int k = 0; k < 6; k++) begin
         h = '0;
         for (int j = 0; j < 4; j++) begin
            h[21 * j + k] = 1'b1;
            h[21 * j + 20] = 1'b1;
         end
         s = 16'h8000 | (16'h1 << k);
         pulse(k, s, h);
         chk_rd(link_addr(k, 0), {16'h0, s});
         for (int j = 0; j < 4; j++) begin
            chk_rd(link_addr(k, 4 + j), 32'h0010_0000 | (32'h1 << k));
         end
         if (k < 5) begin
            chk_rd(link_addr(k + 1, 4), 32'h0);
         end
      end
   endtask

   task automatic t_invert();
      wr(link_addr(0, 0), 32'h0001_8003);
      chk_rd(link_addr(0, 0), 32'h2);
      repeat (4) @(posedge mclk);
      chk_rd(link_addr(0, 0), 32'h2);
      wr(link_addr(3, 7), 32'h0010_0008);
      chk_rd(link_addr(3, 7), 32'h0);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= link_addr(0, 0);
      reg_wdata <= 32'h2;
      link_events[0].sum_ovf <= 16'h2;
      @(posedge mclk);
      reg_wr <= 1'b0;
      link_events[0] <= '0;
      chk_rd(link_addr(0, 0), 32'h2);
   endtask

   task automatic t_irq();
      wr(IRQ_CLEAR_OFFSET, 32'h7f);
      chk_rd(IRQ_STATUS_OFFSET, 32'h0);
      pulse(2, 16'h4, '0);
      combiner_flags <= '{ovf: 6'h0, unf: 6'h0, align: 2'h1};
      repeat (3) @(posedge mclk);
      combiner_flags <= '0;
      chk_rd(IRQ_STATUS_OFFSET, 32'h9);
      `CHK(irq, 1'b0)
      wr(IRQ_ENABLE_OFFSET, 32'h8);
      chk_rd(IRQ_ENABLE_OFFSET, 32'h8);
      `CHK(irq, 1'b1)
      wr(IRQ_ENABLE_OFFSET, 32'h0);
      chk_rd(IRQ_CLEAR_OFFSET, 32'h0);
      `CHK(irq, 1'b0)
      wr(IRQ_ENABLE_OFFSET, 32'h8);
      wr(IRQ_CLEAR_OFFSET, 32'h8);
      chk_rd(IRQ_STATUS_OFFSET, 32'h1);
      `CHK(irq, 1'b0)
      chk_rd(12'h0f0, 32'h0);
   endtask

   task automatic conclude();
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      foreach (link_events[k]) link_events[k] = '0;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_combiner();
      t_links();
      t_invert();
      t_irq();
      conclude();
   end

   initial begin
      #100us;
      errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      conclude();
   end
endmodule
`default_nettype wire
